// [rtl/arc_pkg.sv]
// Purpose: Constants and types for the auto-reclose sequencer.
// Assumes: 40 MHz core clock; all times counted in 0.1 s ticks.
// Notes: Register map is reached over APB, one 32-bit word each.
//
// How it works
// - Up to five cycles, always taken in order one to five, then final trip.
// - Start-initiated cycles open the breaker after starting time; trip ones do not.
// - At dead-time end close only if breaker open; no closing during dead time.
// - Every open or close command needs the interlock permission for it.
// - External start input routes to one of signals a, b or c, or to none when its select is 0.
// - Cycle with signal a setting 0 is inhibited when signal a is active.
// - Per-cycle settings say whether signals b and c start that cycle.
// - Per-cycle starting times for b and c, 0.0 to 5.0 s in 0.1 s.
// - Per-cycle dead time 0.2 to 300.0 s in 0.1 s steps.
// - One reclaim time, 0.2 to 300.0 s, shared by all cycles.
// - Signal a opens the breaker at once with no starting delay.
// - In-progress flag set after starting time, cleared at close; aux mirrors it.
// - After last cycle fails, final trip if enabled, after per-signal delay.
// - Final-trip indication on selected aux output, as long as the open pulse.
// - A start request begins a cycle only when the breaker is closed.
// - Finished cycles blocked during reclaim; new request runs next cycle.
// - Input 10, in-use off or front switch inhibit; reclaim starts on release of input 10, at once for the others.
// - Inhibit input, remote interrupt or open-on-open aborts; reclaim always starts.
// - Local or bus breaker close starts reclaim and inhibits reclosing.
// - Duplex: open both, closed if either, reclose the last one closed.
// - Four counters per cycle: total, a, b, c; bump on breaker close.
// - Events per cycle: progress, close, progress by a/b/c; plus final, abort.
`default_nettype none
package arc_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 22;
  localparam int unsigned NCYC = 5;
  localparam logic [2:0] BASE_BLOCK = 3'h7;
  localparam logic [2:0] CYC_NONE = 3'h7;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RECLAIM = 8'h04;
  localparam logic [7:0] OFS_FTCFG = 8'h08;
  localparam logic [7:0] OFS_FTDLY = 8'h0c;
  localparam logic [7:0] OFS_PULSE = 8'h10;
  localparam logic [7:0] OFS_CYC0 = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_EVENT = 8'h44;
  localparam logic [7:0] OFS_CNT0 = 8'h60;
  // ==========================================================
  // Control fields
  localparam int CTL_IN_USE = 0;
  localparam int CTL_RMT_INT = 1;
  localparam int CTL_EXT_LO = 2;
  localparam int CTL_PROG_SEL = 4;
  localparam int CTL_DUPLEX = 5;
  localparam int CTL_IN10_MODE = 6;
  // Cycle word fields
  localparam int CF_DLYB_LO = 4;
  localparam int CF_DLYC_LO = 12;
  localparam int CF_DEAD_LO = 20;
  // Final-trip config fields
  localparam int FT_SEL_LO = 4;
  // Event bits
  localparam int EV_PER_CYC = 5;
  localparam int EV_FT_LO = 25;
  localparam int EV_ABORT = 28;
  // ==========================================================
  // Reset values
  localparam logic [11:0] RECLAIM_RST = 12'h032;
  localparam logic [15:0] PULSE_RST = 16'h0202;
  // ==========================================================
  // Synchroniser bit positions
  localparam int SI_A = 0;
  localparam int SI_EXT = 3;
  localparam int SI_TRIP = 4;
  localparam int SI_INH = 7;
  localparam int SI_FRONT = 8;
  localparam int SI_CB1 = 9;
  localparam int SI_CB2 = 10;
  localparam int SI_ILKO = 11;
  localparam int SI_ILKC = 12;
  localparam int SI_MCLOSE = 13;
  localparam int SI_MOPEN = 14;
  localparam int SYNC_W = 15;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DEAD, ST_RECLAIM, ST_FINAL
  } arc_state_t;
endpackage
`default_nettype wire

// [rtl/arc_seq.sv]
// Purpose: Auto-reclose sequencer with APB register access.
// Assumes: Pins are asynchronous and pass two flip-flops first.
// Notes: Zero-wait APB slave, pready answers in the access cycle.
`default_nettype none
module arc_seq import arc_pkg::*; #(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [2:0] i_start_init, // Requests a, b, c
  input wire logic i_ext_init, // External start input
  input wire logic [2:0] i_init_by_trip, // Request comes from trip
  input wire logic i_reclose_interrupt_input, // Input 10
  input wire logic i_front_inhibit_switch, // Front switch
  input wire logic i_cb1_closed, // Breaker 1 closed
  input wire logic i_cb2_closed, // Breaker 2 closed
  input wire logic i_ilk_open_ok, // Interlock allows open
  input wire logic i_ilk_close_ok, // Interlock allows close
  input wire logic i_manual_close, // Local or bus close
  input wire logic i_manual_open, // Local or bus open
  output logic o_cb1_open, // Open command breaker 1
  output logic o_cb2_open, // Open command breaker 2
  output logic o_cb1_close, // Close command breaker 1
  output logic o_cb2_close, // Close command breaker 2
  output logic o_in_progress, // Cycle in progress
  output logic o_aux_signal_output_a, // Aux output a
  output logic o_aux_signal_output_b, // Aux output b
  output logic [4:0] o_reclose_output_data // Active cycle one-hot
);
  // ==========================================================
  // Helpers
  function automatic logic [2:0] find_cyc(input logic [2:0] base,
      input logic [1:0] src, input logic a_act,
      input logic [31:0] cfg [NCYC]);
    logic [2:0] f;
    f = CYC_NONE;
    for (int i = 0; i < NCYC; i++) begin
      if (f == CYC_NONE && 3'(i) >= base && cfg[i][src] &&
          !(a_act && !cfg[i][0])) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_RECLAIM || a == OFS_FTCFG ||
      a == OFS_FTDLY || a == OFS_PULSE || a == OFS_STATUS ||
      a == OFS_EVENT || (a >= OFS_CYC0 && a <= OFS_CYC0 + 8'h10 &&
      a[1:0] == 2'h0) || (a >= OFS_CNT0 && a <= OFS_CNT0 + 8'h10 &&
      a[1:0] == 2'h0);
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [SYNC_W-1:0] s1_q, s2_q, prev_q;
  wire [SYNC_W-1:0] raw = {i_manual_open, i_manual_close, i_ilk_close_ok,
    i_ilk_open_ok, i_cb2_closed, i_cb1_closed, i_front_inhibit_switch,
    i_reclose_interrupt_input, i_init_by_trip, i_ext_init, i_start_init};

  // Two stages, plus one more for edge detection
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  // ==========================================================
  // Registers
  logic [31:0] ctrl_q, ftcfg_q, ftdly_q, ev_q;
  logic [11:0] reclaim_q;
  logic [15:0] pulse_q;
  logic [31:0] cyc_q [NCYC];
  logic [31:0] cnt_q [NCYC];
  logic rmt_int_q, pready_q, pslverr_q;
  logic [31:0] prdata_q, rd_w;
  wire wr_en = psel & penable & pready_q & pwrite;
  wire setup = psel & ~penable;

  // Remote interrupt is a write-only pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= '0;
      reclaim_q <= RECLAIM_RST;
      ftcfg_q <= '0;
      ftdly_q <= '0;
      pulse_q <= PULSE_RST;
      rmt_int_q <= 1'b0;
    end else begin
      rmt_int_q <= wr_en && paddr == OFS_CTRL && pwdata[CTL_RMT_INT];
      if (wr_en && paddr == OFS_CTRL) ctrl_q <= pwdata & 32'h0000007d;
      if (wr_en && paddr == OFS_RECLAIM) reclaim_q <= pwdata[11:0];
      if (wr_en && paddr == OFS_FTCFG) ftcfg_q <= pwdata & 32'h00000077;
      if (wr_en && paddr == OFS_FTDLY) ftdly_q <= pwdata & 32'h00ffffff;
      if (wr_en && paddr == OFS_PULSE) pulse_q <= pwdata[15:0];
    end
  end

  // Per-cycle settings words
  for (genvar g = 0; g < NCYC; g++) begin : g_cyc
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cyc_q[g] <= '0;
      end else if (wr_en && paddr == OFS_CYC0 + 8'(4 * g)) begin
        cyc_q[g] <= pwdata;
      end
    end
  end

  // ==========================================================
  // Derived conditions
  wire [1:0] ext_sel = ctrl_q[CTL_EXT_LO +: 2];
  wire [2:0] ext_map = (ext_sel == 2'h0) ? 3'h0 :
    3'(3'h1 << (ext_sel - 2'h1));
  wire [2:0] req = s2_q[SI_A +: 3] | (ext_map & {3{s2_q[SI_EXT]}});
  wire [2:0] req_prev = prev_q[SI_A +: 3] |
    (ext_map & {3{prev_q[SI_EXT]}});
  wire [2:0] rise = req & ~req_prev;
  wire duplex = ctrl_q[CTL_DUPLEX];
  wire cb_closed = s2_q[SI_CB1] | (duplex & s2_q[SI_CB2]);
  wire inh10 = ctrl_q[CTL_IN10_MODE] & s2_q[SI_INH];
  wire inhibit = ~ctrl_q[CTL_IN_USE] | s2_q[SI_FRONT] | inh10;
  wire mclose_rise = s2_q[SI_MCLOSE] & ~prev_q[SI_MCLOSE];
  wire mopen_rise = s2_q[SI_MOPEN] & ~prev_q[SI_MOPEN];
  wire [1:0] new_src = rise[0] ? 2'h0 : (rise[1] ? 2'h1 : 2'h2);
  wire start_ok = (|rise) & cb_closed & ~inhibit;

  // ==========================================================
  // Tick prescaler
  logic [TICK_W-1:0] pre_q;
  wire tick = pre_q == TICK_W'(P_TICK_CYCLES - 1);

  // Common 0.1 s tick
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) pre_q <= '0;
    else pre_q <= tick ? '0 : pre_q + 1'b1;
  end

  // ==========================================================
  // Sequencer
  arc_state_t st_q, st_d;
  logic [11:0] tmr_q, tmr_d;
  logic [2:0] cyc_sel_q, cyc_d, base_q, base_d, found;
  logic [1:0] src_q, src_d;
  logic open_go, close_go, ft_go, prog_go, abort_go, begin_go;
  logic in_prog_q, last_cb2_q;
  wire seq_active = st_q == ST_START || st_q == ST_DEAD ||
    st_q == ST_FINAL;
  wire abort = seq_active & (inhibit | rmt_int_q |
    (st_q == ST_DEAD & mopen_rise & ~cb_closed));
  wire [11:0] tmr_run = (tick && tmr_q != 12'h000) ? tmr_q - 12'h001 :
    tmr_q;
  wire [31:0] cur_cfg = cyc_q[cyc_sel_q];
  wire [11:0] start_dly = (new_src == 2'h0) ? 12'h000 :
    (new_src == 2'h1) ? 12'(found == CYC_NONE ? 8'h00 :
    cyc_q[found][CF_DLYB_LO +: 8]) : 12'(found == CYC_NONE ? 8'h00 :
    cyc_q[found][CF_DLYC_LO +: 8]);
  wire [11:0] ft_dly = 12'(ftdly_q[8 * new_src +: 8]);

  assign found = find_cyc((st_q == ST_IDLE) ? 3'h0 : base_q, new_src,
    req[0], cyc_q);

  // Next state of the sequence
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_run;
    cyc_d = cyc_sel_q;
    base_d = base_q;
    src_d = src_q;
    open_go = 1'b0;
    close_go = 1'b0;
    ft_go = 1'b0;
    prog_go = 1'b0;
    abort_go = 1'b0;
    begin_go = 1'b0;
    if (abort) begin
      abort_go = 1'b1;
      st_d = ST_RECLAIM;
      tmr_d = reclaim_q;
      base_d = BASE_BLOCK;
    end else if (mclose_rise) begin
      st_d = ST_RECLAIM;
      tmr_d = reclaim_q;
      base_d = BASE_BLOCK;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_RECLAIM: begin
          if (st_q == ST_RECLAIM && inh10) begin
            tmr_d = reclaim_q;
          end else if (start_ok && (st_q == ST_IDLE ||
              base_q != BASE_BLOCK)) begin
            if (found != CYC_NONE) begin
              begin_go = 1'b1;
              st_d = ST_START;
              cyc_d = found;
              src_d = new_src;
              tmr_d = start_dly;
            end else if (st_q == ST_RECLAIM && base_q != 3'h0 &&
                ftcfg_q[new_src]) begin
              st_d = ST_FINAL;
              src_d = new_src;
              tmr_d = ft_dly;
            end
          end else if (st_q == ST_RECLAIM && tmr_q == 12'h000 &&
              req == 3'h0) begin
            st_d = ST_IDLE;
            base_d = 3'h0;
          end
        end
        ST_START: begin
          if (tmr_q == 12'h000) begin
            prog_go = 1'b1;
            open_go = ~s2_q[SI_TRIP + src_q] & s2_q[SI_ILKO];
            st_d = ST_DEAD;
            tmr_d = cur_cfg[CF_DEAD_LO +: 12];
          end
        end
        ST_DEAD: begin
          if (tmr_q == 12'h000) begin
            close_go = ~cb_closed & s2_q[SI_ILKC];
            st_d = ST_RECLAIM;
            tmr_d = reclaim_q;
            base_d = cyc_sel_q + 3'h1;
          end
        end
        ST_FINAL: begin
          if (tmr_q == 12'h000) begin
            open_go = s2_q[SI_ILKO];
            ft_go = 1'b1;
            st_d = ST_RECLAIM;
            tmr_d = reclaim_q;
            base_d = BASE_BLOCK;
          end
        end
      endcase
    end
  end

  // Sequence state registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      cyc_sel_q <= '0;
      base_q <= '0;
      src_q <= '0;
      in_prog_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      cyc_sel_q <= cyc_d;
      base_q <= base_d;
      src_q <= src_d;
      in_prog_q <= st_d == ST_DEAD && (prog_go | in_prog_q);
    end
  end

  // ==========================================================
  // Command pulses and outputs
  logic [7:0] open_cnt_q, close_cnt_q, ft_cnt_q;
  logic ft_to_b_q;
  wire [7:0] open_len = (pulse_q[7:0] == 8'h00) ? 8'h01 : pulse_q[7:0];
  wire [7:0] close_len = (pulse_q[15:8] == 8'h00) ? 8'h01 :
    pulse_q[15:8];
  wire ft_on = ft_cnt_q != 8'h00;
  wire cb1_rise = s2_q[SI_CB1] & ~prev_q[SI_CB1];
  wire cb2_rise = s2_q[SI_CB2] & ~prev_q[SI_CB2];
  wire prog_b = ctrl_q[CTL_PROG_SEL];

  // Pulse counters run on the tick
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open_cnt_q <= '0;
      close_cnt_q <= '0;
      ft_cnt_q <= '0;
      ft_to_b_q <= 1'b0;
      last_cb2_q <= 1'b0;
    end else begin
      if (open_go) open_cnt_q <= open_len;
      else if (tick && open_cnt_q != 8'h00) open_cnt_q <= open_cnt_q - 1'b1;
      if (close_go) close_cnt_q <= close_len;
      else if (tick && close_cnt_q != 8'h00)
        close_cnt_q <= close_cnt_q - 1'b1;
      if (ft_go) ft_cnt_q <= open_len;
      else if (tick && ft_on) ft_cnt_q <= ft_cnt_q - 1'b1;
      if (ft_go) ft_to_b_q <= ftcfg_q[FT_SEL_LO + src_q];
      if (cb2_rise) last_cb2_q <= 1'b1;
      else if (cb1_rise) last_cb2_q <= 1'b0;
    end
  end

  // Registered pins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cb1_open <= 1'b0;
      o_cb2_open <= 1'b0;
      o_cb1_close <= 1'b0;
      o_cb2_close <= 1'b0;
      o_in_progress <= 1'b0;
      o_aux_signal_output_a <= 1'b0;
      o_aux_signal_output_b <= 1'b0;
      o_reclose_output_data <= '0;
    end else begin
      o_cb1_open <= open_cnt_q != 8'h00;
      o_cb2_open <= duplex && open_cnt_q != 8'h00;
      o_cb1_close <= close_cnt_q != 8'h00 && !(duplex && last_cb2_q);
      o_cb2_close <= close_cnt_q != 8'h00 && duplex && last_cb2_q;
      o_in_progress <= in_prog_q;
      o_aux_signal_output_a <= (in_prog_q & ~prog_b) | (ft_on & ~ft_to_b_q);
      o_aux_signal_output_b <= (in_prog_q & prog_b) | (ft_on & ft_to_b_q);
      o_reclose_output_data <= seq_active ? 5'(5'h01 << cyc_sel_q) : '0;
    end
  end

  // ==========================================================
  // Events and counters
  logic [31:0] ev_set;
  wire [31:0] ev_clr = (wr_en && paddr == OFS_EVENT) ? pwdata : '0;

  // Event bits for the running cycle
  always_comb begin
    ev_set = '0;
    if (prog_go) begin
      ev_set[EV_PER_CYC * cyc_sel_q] = 1'b1;
      ev_set[EV_PER_CYC * cyc_sel_q + 2 + src_q] = 1'b1;
    end
    if (close_go) ev_set[EV_PER_CYC * cyc_sel_q + 1] = 1'b1;
    if (ft_go) ev_set[EV_FT_LO + src_q] = 1'b1;
    if (abort_go) ev_set[EV_ABORT] = 1'b1;
  end

  // Sticky events, write one to clear, a new set wins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) ev_q <= '0;
    else ev_q <= (ev_q & ~ev_clr) | ev_set;
  end

  // Total and per-signal counts for each cycle
  for (genvar g = 0; g < NCYC; g++) begin : g_cnt
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cnt_q[g] <= '0;
      end else if (close_go && cyc_sel_q == 3'(g)) begin
        cnt_q[g][7:0] <= cnt_q[g][7:0] + 8'h01;
        cnt_q[g][8 * (src_q + 1) +: 8] <=
          cnt_q[g][8 * (src_q + 1) +: 8] + 8'h01;
      end
    end
  end

  // ==========================================================
  // APB read path
  always_comb begin
    rd_w = '0;
    if (paddr == OFS_CTRL) rd_w = ctrl_q;
    else if (paddr == OFS_RECLAIM) rd_w = 32'(reclaim_q);
    else if (paddr == OFS_FTCFG) rd_w = ftcfg_q;
    else if (paddr == OFS_FTDLY) rd_w = ftdly_q;
    else if (paddr == OFS_PULSE) rd_w = 32'(pulse_q);
    else if (paddr == OFS_STATUS)
      rd_w = 32'({base_q, cyc_sel_q, 3'(st_q), in_prog_q, cb_closed});
    else if (paddr == OFS_EVENT) rd_w = ev_q;
    else if (reg_hit(paddr) && paddr < OFS_STATUS)
      rd_w = cyc_q[3'((paddr - OFS_CYC0) >> 2)];
    else if (reg_hit(paddr)) rd_w = cnt_q[3'((paddr - OFS_CNT0) >> 2)];
  end

  // Answer is ready in the first access cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~reg_hit(paddr);
      prdata_q <= (setup && !pwrite) ? rd_w : '0;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_close_gate: assert property (
    close_go |-> st_q == ST_DEAD && !cb_closed && tmr_q == 12'h000)
    else $error("close given outside end of dead time");
  a_dead_no_close: assert property (
    st_q == ST_DEAD |-> ##2 !(o_cb1_close || o_cb2_close) ||
      $past(close_go, 2))
    else $error("close command during dead time");
  a_open_interlock: assert property (
    open_go |-> s2_q[SI_ILKO])
    else $error("open issued without interlock permission");
  a_cycle_order: assert property (
    st_q == ST_RECLAIM && st_d == ST_START |-> cyc_d >= base_q)
    else $error("earlier cycle repeated during reclaim");
  a_start_closed: assert property (
    begin_go |-> cb_closed ##1 st_q == ST_START)
    else $error("cycle began with breaker open");
  a_init_a_now: assert property (
    begin_go && new_src == 2'h0 |=> prog_go ##1 st_q == ST_DEAD)
    else $error("signal a start was delayed");
  a_progress_clr: assert property (
    close_go |=> !in_prog_q ##1 !o_in_progress)
    else $error("progress flag held past close");
  a_inhibit_idle: assert property (
    st_q == ST_IDLE && inhibit |=> st_q == ST_IDLE)
    else $error("sequence started while inhibited");
  a_abort_reclaim: assert property (
    abort |=> st_q == ST_RECLAIM && tmr_q == reclaim_q)
    else $error("abort did not start reclaim");
  a_count_total: assert property (
    close_go && cyc_sel_q == 3'h0 |=>
      cnt_q[0][7:0] == $past(cnt_q[0][7:0]) + 8'h01)
    else $error("total count not bumped on close");

  c_full_cycle: cover property (prog_go ##[1:1000] close_go);
  c_final_trip: cover property (ft_go);
  c_abort: cover property (abort_go);
  c_second_cycle: cover property (begin_go && found == 3'h1);
endmodule
`default_nettype wire

// [testbench/arc_cb_model.sv]
// Purpose: Breaker model that answers open and close commands.
// Assumes: Breaker starts closed; status moves P_DLY+1 clocks after a command.
// Notes: P_DLY of 1 answers promptly, larger values answer slowly.
`default_nettype none
module arc_cb_model #(
  parameter int P_DLY = 2
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_open, // Open command pulse
  input wire logic i_close, // Close command pulse
  output logic o_closed // Breaker closed status
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] open_q;
  logic [7:0] close_q;
  // Commands pass a delay line before the contacts move
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open_q <= '0;
      close_q <= '0;
      o_closed <= 1'b1;
    end else begin
      open_q <= {open_q[6:0], i_open};
      close_q <= {close_q[6:0], i_close};
      if (open_q[P_DLY-1])
        o_closed <= 1'b0;
      else if (close_q[P_DLY-1])
        o_closed <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for the auto-reclose sequencer.
// Assumes: Tick shortened to 4 clocks; breaker model answers in 3.
// Notes: Reset reads run from a table, sequences are hand-written.
`default_nettype none
module tb import arc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 4;
  // Reset rows: address, expected data, expected error
  localparam logic [7:0] RA [5] = '{OFS_CTRL, OFS_RECLAIM, OFS_PULSE,
    OFS_EVENT, 8'hfc};
  localparam logic [31:0] RV [5] = '{32'h0, 32'h32, 32'h202, 32'h0, 32'h0};
  localparam logic RE [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic i_core_clk = 0;
  logic i_rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, r;
  logic pready, pslverr, er, cb1, o1, c1, prog, aux_a;
  logic [2:0] start = '0;
  logic front = 0;
  logic ilk = 1;
  logic mclose = 0;
  logic [4:0] cyc;
  logic seen_prog = 0;
  logic aux_bad = 0;
  int mismatches = 0;
  int cmp_count = 0;
  int t, t2;
  always #12.5 i_core_clk = ~i_core_clk;
  // ==========================================================
  // Design and breaker model
  arc_seq #(.P_TICK_CYCLES(TK)) i_dut (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_start_init(start), .i_ext_init(1'b0),
    .i_init_by_trip(3'h0), .i_reclose_interrupt_input(1'b0),
    .i_front_inhibit_switch(front), .i_cb1_closed(cb1),
    .i_cb2_closed(1'b0), .i_ilk_open_ok(ilk), .i_ilk_close_ok(ilk),
    .i_manual_close(mclose), .i_manual_open(1'b0), .o_cb1_open(o1),
    .o_cb2_open(), .o_cb1_close(c1), .o_cb2_close(), .o_in_progress(prog),
    .o_aux_signal_output_a(aux_a), .o_aux_signal_output_b(),
    .o_reclose_output_data(cyc));
  arc_cb_model #(.P_DLY(2)) i_cb (.i_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_open(o1), .i_close(c1), .o_closed(cb1));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge i_core_clk);
    end
    if (n == 20)
      mismatches++;
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for open (k=0) or close (k=1), watching the progress flag
  task automatic wcmd(input bit k, input int lim, output int c);
    c = 0;
    while (((k ? c1 : o1) !== 1'b1) && c < lim) begin
      @(posedge i_core_clk);
      c++;
      if (prog === 1'b1)
        seen_prog = 1'b1;
      if (aux_a !== prog)
        aux_bad = 1'b1;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk("reg_read", r, RV[i]);
      chk("slverr", {31'h0, er}, {31'h0, RE[i]});
    end
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_RECLAIM, 32'h2);
    apb(1'b1, OFS_CYC0, 32'h0030_0001);
    @(posedge i_core_clk);
    start <= 3'h1;
    wcmd(1'b0, 40, t);
    chk("open_fast", t, 32'd6);
    chk("cycle_out", {27'h0, cyc}, 32'h1);
    start <= 3'h0;
    wcmd(1'b1, 200, t2);
    chk("dead_gap", 32'(t2 >= 2 * TK), 32'h1);
    chk("close_seen", {31'h0, c1}, 32'h1);
    chk("prog_seen", {31'h0, seen_prog}, 32'h1);
    chk("aux_mirror", {31'h0, aux_bad}, 32'h0);
    repeat (20) @(posedge i_core_clk);
    chk("prog_clear", {31'h0, prog}, 32'h0);
    apb(1'b0, OFS_CNT0, 32'h0);
    chk("counters", r, 32'h0000_0101);
    apb(1'b0, OFS_EVENT, 32'h0);
    chk("events", r & 32'h1f, 32'h07);
    // Front switch, a-inhibit of a b start, interlock refusal, manual
    // close reclaim: none of them may open the breaker
    for (int i = 0; i < 4; i++) begin
      repeat (60) @(posedge i_core_clk);
      front <= (i == 0);
      ilk <= (i != 2);
      mclose <= (i == 3);
      apb(1'b1, OFS_CYC0, (i == 1) ? 32'h0030_0002 : 32'h0030_0001);
      start <= 3'h1;
      if (i == 1) begin
        repeat (4) @(posedge i_core_clk);
        start <= 3'h3;
      end
      wcmd(1'b0, 60, t);
      chk("no_open", {31'h0, o1}, 32'h0);
      start <= 3'h0;
      front <= 1'b0;
    end
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
